//--- src/act_timer.sv
// Delay manager: step timer, captures, multiplier, auto prescaler and debug pins.
`timescale 1ns/1ps
`include "act_params.svh"
module act_timer (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   // Avalon-MM slave
   input  wire logic [5:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   input  wire logic [3:0]  i_byteenable,
   output logic      [31:0] o_readdata,
   output logic             o_waitrequest,
   // Rotor position events, one-cycle pulses
   input  wire logic        i_zero_cross_event,
   input  wire logic        i_demag_event,
   input  wire logic        i_capture_event,
   input  wire logic        i_update_event,
   // Event and pin outputs
   output logic             o_commutation,
   output logic             o_ratio_irq,
   output logic             o_zero_debug_pin,
   output logic             o_demag_debug_pin,
   output act_pkg::act_stepcfg_s o_stepcfg,
   output act_pkg::act_phase_s   o_phase
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   act_pkg::act_ctrl_s    ctrl;
   act_pkg::act_stepcfg_s stepcfg_pre;
   act_pkg::act_phase_s   phase_pre;
   act_pkg::act_bus_e     bus_state;
   logic [7:0] step_timer;
   logic [7:0] zero_cross_capture;
   logic [7:0] zero_cross_previous;
   logic [7:0] commutation_compare;
   logic [7:0] demag_compare;
   logic [7:0] phase_weight;
   logic [3:0] step_prescaler;
   logic [14:0] tick_count;
   logic       ratio_increment_flag;
   logic       ratio_decrement_flag;
   logic       overflow_flag;
   logic       compare_armed;
   logic       mult_pending;
   logic       zero_glitch;
   logic       demag_toggle;
   logic       zero_toggle;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire        bus_access = (i_read || i_write) && (bus_state == act_pkg::ACT_IDLE);
   wire        wr         = i_write && (bus_state == act_pkg::ACT_BUSY) && i_byteenable[0];
   wire [3:0]  reg_sel    = i_address[5:2];
   wire        running    = ctrl.clock_enable;
   wire [7:0]  wd         = i_writedata[7:0];
   wire        wr_comp    = wr && (reg_sel == `ACT_ADDR_COMP);
   wire        wr_zcap    = wr && (reg_sel == `ACT_ADDR_ZCAP);
   wire        wr_phase   = wr && (reg_sel == `ACT_ADDR_PHASE);
   wire        wr_status  = wr && (reg_sel == `ACT_ADDR_STATUS);
   wire        autosw     = running && ctrl.switch_mode_select;
   wire        sim_c      = ctrl.sim_commutation_enable;
   act_pkg::act_ctrl_s wd_ctrl;
   assign wd_ctrl = act_pkg::act_ctrl_s'(wd);
   wire        sim_rise   = wr && (reg_sel == `ACT_ADDR_CTRL) && wd_ctrl.sim_commutation_enable
                            && !sim_c;

   // ---------------------------------------------------------------
   // Timebase: prescaler 2^n clock ticks per timer step
   // ---------------------------------------------------------------
   wire [14:0] tick_limit = 15'((16'h0001 << step_prescaler) - 16'h0001);
   wire        tick       = running && (tick_count >= tick_limit);
   wire [8:0]  timer_inc  = {1'b0, step_timer} + 9'h001;
   wire        at_limit   = tick && (timer_inc == `ACT_TIMER_LIMIT);
   wire        presc_top  = (step_prescaler == `ACT_PRESC_MAX);
   wire        shift_down = autosw && at_limit && !presc_top;
   wire        wrap       = running && at_limit && !shift_down;
   wire        zero_event = autosw && i_zero_cross_event;
   wire        sim_zero   = autosw && wr_zcap && sim_c;
   wire        any_zero   = zero_event || sim_zero;
   wire        shift_up   = zero_event && (step_timer < `ACT_TIMER_LOW)
                            && (step_prescaler != 4'h0);

   // ---------------------------------------------------------------
   // Multiplier and compare check
   // ---------------------------------------------------------------
   wire [7:0]  mult_src   = ctrl.delay_source_select ? zero_cross_capture : zero_cross_previous;
   wire [15:0] product    = phase_weight * mult_src;
   wire [7:0]  mult_res   = product[15:`ACT_WEIGHT_SHIFT];
   wire        comp_ready = running && compare_armed && !mult_pending;
   wire        commutate  = comp_ready && (commutation_compare <= step_timer);

   // ---------------------------------------------------------------
   // Timer and capture registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         step_timer          <= 8'h00;
         zero_cross_capture  <= 8'h00;
         zero_cross_previous <= 8'h00;
         demag_compare       <= 8'h00;
         tick_count          <= 15'h0000;
      end else begin
         tick_count <= (tick || !running || any_zero) ? 15'h0000 : tick_count + 15'h0001;
         if (!running && wr) begin
            if (reg_sel == `ACT_ADDR_TIMER) step_timer <= wd;
            if (reg_sel == `ACT_ADDR_ZCAP) zero_cross_capture <= wd;
            if (reg_sel == `ACT_ADDR_ZPRV) zero_cross_previous <= wd;
            if (reg_sel == `ACT_ADDR_DEMAG) demag_compare <= wd;
         end else if (zero_event) begin
            zero_cross_previous <= shift_up ? {zero_cross_capture[6:0], 1'b0} : zero_cross_capture;
            zero_cross_capture  <= shift_up ? {step_timer[6:0], 1'b0} : step_timer;
            demag_compare       <= shift_up ? {demag_compare[6:0], 1'b0} : demag_compare;
            step_timer          <= 8'h00;
         end else if (sim_zero) begin
            zero_cross_previous <= wd;
            zero_cross_capture  <= wd;
            step_timer          <= 8'h00;
         end else if (shift_down) begin
            step_timer          <= `ACT_TIMER_MEDIAN;
            zero_cross_capture  <= {1'b0, zero_cross_capture[7:1]};
            zero_cross_previous <= {1'b0, zero_cross_previous[7:1]};
            demag_compare       <= {1'b0, demag_compare[7:1]};
         end else if (running && wr && reg_sel == `ACT_ADDR_DEMAG) begin
            demag_compare <= wd;
         end else if (tick) begin
            step_timer <= timer_inc[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Commutation compare
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         commutation_compare <= 8'h00;
         compare_armed       <= 1'b0;
         mult_pending        <= 1'b0;
      end else begin
         // Turning simulated commutation on cancels a pending hardware result.
         mult_pending <= autosw && !sim_c && !sim_rise
                         && (any_zero || shift_down || shift_up);
         if (wr_comp) begin
            commutation_compare <= wd;
            compare_armed       <= running;
         end else if (commutate) begin
            commutation_compare <= step_timer;
            compare_armed       <= 1'b0;
         end else if (mult_pending) begin
            commutation_compare <= mult_res;
            compare_armed       <= 1'b1;
         end else if (shift_down) begin
            commutation_compare <= {1'b0, commutation_compare[7:1]};
         end else if (shift_up) begin
            commutation_compare <= {commutation_compare[6:0], 1'b0};
         end else if (sim_c && any_zero) begin
            compare_armed <= 1'b0;
         end
         // A stale hardware compare must not fire once software takes over.
         if (sim_rise) compare_armed <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Control, prescaler and flags
   // ---------------------------------------------------------------
   wire wr_presc = wr && (reg_sel == `ACT_ADDR_PRESC) && !running;
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         ctrl                 <= '0;
         phase_weight         <= `ACT_RST_WEIGHT;
         step_prescaler       <= `ACT_RST_PRESC;
         ratio_increment_flag <= 1'b0;
         ratio_decrement_flag <= 1'b0;
         overflow_flag        <= 1'b0;
         stepcfg_pre          <= '0;
         phase_pre            <= '0;
         o_stepcfg            <= '0;
         o_phase              <= '0;
      end else begin
         if (wr && reg_sel == `ACT_ADDR_CTRL) ctrl <= act_pkg::act_ctrl_s'(i_writedata[7:0]);
         if (wr && reg_sel == `ACT_ADDR_WEIGHT) phase_weight <= wd;
         if (wr_presc) step_prescaler <= wd[3:0];
         else if (shift_down) step_prescaler <= step_prescaler + 4'h1;
         else if (shift_up) step_prescaler <= step_prescaler - 4'h1;
         // Hardware set wins over a software clear in the same cycle.
         ratio_increment_flag <= shift_down || (ratio_increment_flag && !(wr_status && wd[0]));
         ratio_decrement_flag <= shift_up || (ratio_decrement_flag && !(wr_status && wd[1]));
         overflow_flag <= (at_limit && running && ctrl.sensor_type_select == `ACT_TES_NONE)
                          || (overflow_flag && !(wr_status && wd[2]));
         if (wr && reg_sel == `ACT_ADDR_STEPCFG) stepcfg_pre <= act_pkg::act_stepcfg_s'(wd[3:0]);
         if (wr_phase) phase_pre <= act_pkg::act_phase_s'(wd);
         if (commutate) o_stepcfg <= stepcfg_pre;
         if (commutate) o_phase <= phase_pre;
         else if (wr_phase && !autosw) o_phase <= act_pkg::act_phase_s'(wd);
      end
   end

   // Ratio interrupt: prescaler step changes only, gated by the mask.
   assign o_ratio_irq = ctrl.ratio_irq_mask
                        && (ratio_increment_flag || ratio_decrement_flag);
   assign o_commutation = commutate;

   // ---------------------------------------------------------------
   // Debug pins
   // ---------------------------------------------------------------
   wire speed_mode = ctrl.sensor_type_select != `ACT_TES_NONE;
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         zero_glitch       <= 1'b0;
         demag_toggle      <= 1'b0;
         zero_toggle       <= 1'b0;
         o_zero_debug_pin  <= 1'b0;
         o_demag_debug_pin <= 1'b0;
      end else begin
         zero_glitch  <= any_zero;
         demag_toggle <= demag_toggle ^ (speed_mode ? i_capture_event : commutate);
         zero_toggle  <= zero_toggle ^ (speed_mode && i_update_event);
         if (!ctrl.debug_output_enable) begin
            o_zero_debug_pin  <= 1'b0;
            o_demag_debug_pin <= 1'b0;
         end else if (speed_mode) begin
            o_zero_debug_pin  <= zero_toggle;
            o_demag_debug_pin <= demag_toggle;
         end else begin
            // A zero event is shown one cycle even when commutation follows at once.
            o_zero_debug_pin  <= any_zero || (zero_glitch && !commutate);
            o_demag_debug_pin <= demag_toggle ^ i_demag_event;
         end
      end
   end

   // ---------------------------------------------------------------
   // Avalon-MM slave: one wait cycle on every access
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rstn) bus_state <= act_pkg::ACT_IDLE;
      else if (bus_access) bus_state <= act_pkg::ACT_BUSY;
      else bus_state <= act_pkg::ACT_IDLE;
   end
   assign o_waitrequest = (i_read || i_write) && (bus_state != act_pkg::ACT_BUSY);

   logic [7:0] rd_mux;
   always_comb begin
      case (reg_sel)
         `ACT_ADDR_TIMER:   rd_mux = step_timer;
         `ACT_ADDR_ZCAP:    rd_mux = zero_cross_capture;
         `ACT_ADDR_ZPRV:    rd_mux = zero_cross_previous;
         `ACT_ADDR_COMP:    rd_mux = commutation_compare;
         `ACT_ADDR_DEMAG:   rd_mux = demag_compare;
         `ACT_ADDR_WEIGHT:  rd_mux = phase_weight;
         `ACT_ADDR_PRESC:   rd_mux = {4'h0, step_prescaler};
         `ACT_ADDR_CTRL:    rd_mux = ctrl;
         `ACT_ADDR_STATUS:  rd_mux = {5'h00, overflow_flag, ratio_decrement_flag,
                                      ratio_increment_flag};
         `ACT_ADDR_STEPCFG: rd_mux = {4'h0, stepcfg_pre};
         `ACT_ADDR_PHASE:   rd_mux = phase_pre;
         default:           rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge i_clock) begin
      if (!i_rstn) o_readdata <= 32'h00000000;
      else if (bus_access && i_read) o_readdata <= {24'h000000, rd_mux};
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_COMM_TAKES_TIMER: assert property (@(posedge i_clock) disable iff (!i_rstn)
      commutate |=> commutation_compare == $past(step_timer) || $past(wr_comp))
      else $error("compare not overwritten by timer on commutation");
   wire [7:0] next_previous = shift_up ? {zero_cross_capture[6:0], 1'b0} : zero_cross_capture;
   AST_ZERO_RESETS: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (zero_event && running) |=> step_timer == 8'h00
                                  && zero_cross_previous == $past(next_previous))
      else $error("zero-cross did not reset and capture");
   AST_SIM_NO_WRITE: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (sim_c && !compare_armed && !wr_comp) |=> !compare_armed)
      else $error("compare armed without a software write");
   AST_PRESC_UP: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (shift_down && !zero_event && !sim_zero && !wr_presc) |=>
         step_timer == 8'h80 && step_prescaler == $past(step_prescaler) + 4'h1)
      else $error("overflow rescale wrong");
   AST_PRESC_FLOOR: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (step_prescaler == 4'h0 && !wr_presc) |=> step_prescaler != 4'hf)
      else $error("prescaler decremented below zero");
   AST_TOP_WRAP: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (wrap && presc_top && !any_zero && !wr) |=> step_timer == 8'h00 && !$rose(ratio_increment_flag))
      else $error("wrap at top prescaler wrong");
   AST_MULT_LOAD: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (mult_pending && !wr_comp && !commutate) |=> commutation_compare == $past(mult_res))
      else $error("multiplier result not loaded");
   AST_PRELOAD: assert property (@(posedge i_clock) disable iff (!i_rstn)
      commutate |=> o_stepcfg == $past(stepcfg_pre))
      else $error("step preload not transferred");
   AST_IRQ: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (shift_down && ctrl.ratio_irq_mask && !wr_status && !(wr && reg_sel == `ACT_ADDR_CTRL)) |=> o_ratio_irq)
      else $error("ratio interrupt missing");

endmodule : act_timer

//--- common/act_params.svh
// Constants of the autoswitched commutation timer.
// Function
// - Commutation events never alter the step timer count in autoswitched mode.
// - Hardware zero-cross captures timer, shifts previous capture, resets timer.
// - Simulated zero-cross shifts written capture into previous, resets timer.
// - Compare equals weight times selected capture divided by 256 when not simulated.
// - Compare at or below timer fires commutation at once and takes timer value.
// - Multiplication is recomputed after every prescaler shift outside simulated mode.
// - Simulated mode compares only after a software write to compare register.
// - Simulated mode accepts consecutive commutations without demagnetization.
// - Timer overflow raises ratio-increment interrupt when ratio mask is set.
// - Simulated mode still honours demag and zero-cross; zero-cross resets timer.
// - At 100h prescaler increments, registers halve, flags set, count from 80h.
// - Zero-cross below 55h decrements prescaler, doubles registers, sets decrement flag.
// - Prescaler zero is never decremented and raises no decrement interrupt.
// - Prescaler 15 wraps timer FFh to 00h, only overflow flag set.
// - Rescaling covers timer, capture, previous, compare and demag compare together.
// - Debug enable drives commutation, demag and zero events on two debug pins.
// - Zero delay coefficient gives a glitch on the zero debug pin.
// - Speed measurement: demag pin toggles on capture, zero pin on update.
// - Step configuration preloads transfer at commutation; phase state also at its write when not autoswitched.
// - Registers freely writable until clock enabled; then ratio only steps.
// - Switch-mode select 0 is switched, 1 autoswitched with automatic commutation.
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH
`define ACT_ADDR_TIMER      4'h0
`define ACT_ADDR_ZCAP       4'h1
`define ACT_ADDR_ZPRV       4'h2
`define ACT_ADDR_COMP       4'h3
`define ACT_ADDR_DEMAG      4'h4
`define ACT_ADDR_WEIGHT     4'h5
`define ACT_ADDR_PRESC      4'h6
`define ACT_ADDR_CTRL       4'h7
`define ACT_ADDR_STATUS     4'h8
`define ACT_ADDR_STEPCFG    4'h9
`define ACT_ADDR_PHASE      4'ha
`define ACT_ADDR_MASK       4'hf
`define ACT_TIMER_LIMIT     9'h100
`define ACT_TIMER_MEDIAN    8'h80
`define ACT_TIMER_LOW       8'h55
`define ACT_PRESC_MAX       4'hf
`define ACT_TES_NONE        2'h0
`define ACT_RST_WEIGHT      8'h00
`define ACT_RST_PRESC       4'h0
`define ACT_WEIGHT_SHIFT    8
`endif

//--- common/act_pkg.sv
// Types of the autoswitched commutation timer.
package act_pkg;
   typedef struct packed {
      logic       clock_enable;
      logic       switch_mode_select;
      logic       sim_commutation_enable;
      logic       delay_source_select;
      logic       debug_output_enable;
      logic [1:0] sensor_type_select;
      logic       ratio_irq_mask;
   } act_ctrl_s;
   typedef struct packed {
      logic       compare_polarity_bit;
      logic       hw_demag_enable;
      logic       sim_demag_enable;
      logic       output_sel_two;
   } act_stepcfg_s;
   typedef struct packed {
      logic [1:0] input_select;
      logic [5:0] output_phase_pattern;
   } act_phase_s;
   typedef enum logic [1:0] {
      ACT_IDLE = 2'b01,
      ACT_BUSY = 2'b10
   } act_bus_e;
endpackage : act_pkg

//--- verification/act_event_source.sv
// Partner model: rotor position detectors that send single-cycle event pulses.
`timescale 1ns/1ps
module act_event_source (
   // Clock
   input  wire logic i_clock,
   // Detector events
   output logic      o_zero_cross_event,
   output logic      o_demag_event,
   output logic      o_capture_event,
   output logic      o_update_event
);
   initial begin
      o_zero_cross_event = 1'b0;
      o_demag_event      = 1'b0;
      o_capture_event    = 1'b0;
      o_update_event     = 1'b0;
   end
   // Pulses last exactly one cycle, so the block never sees one event twice.
   task automatic pulse(input logic [3:0] which);
      o_zero_cross_event <= which[0];
      o_demag_event      <= which[1];
      o_capture_event    <= which[2];
      o_update_event     <= which[3];
      @(posedge i_clock);
      o_zero_cross_event <= 1'b0;
      o_demag_event      <= 1'b0;
      o_capture_event    <= 1'b0;
      o_update_event     <= 1'b0;
   endtask : pulse
endmodule : act_event_source

//--- verification/autoswitched_commutation_timer_bench.sv
// Self-checking bench of the autoswitched commutation timer.
`timescale 1ns/1ps
module autoswitched_commutation_timer_bench;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic                  i_clock, i_rstn, i_read, i_write, dbg0;
   logic [5:0]            i_address;
   logic [31:0]           i_writedata, o_readdata;
   logic [3:0]            i_byteenable;
   logic                  o_waitrequest, o_commutation, o_ratio_irq, zdbg, ddbg;
   logic                  zc_ev, dm_ev, cp_ev, up_ev;
   act_pkg::act_stepcfg_s o_stepcfg;
   act_pkg::act_phase_s   o_phase;
   logic [7:0]            exp_q[$];
   logic [7:0]            wgt, cfg, ph;
   int                    n_mismatch, total_checks, n_comm;
   act_timer u_act_timer (.i_clock(i_clock), .i_rstn(i_rstn), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_zero_cross_event(zc_ev), .i_demag_event(dm_ev), .i_capture_event(cp_ev),
      .i_update_event(up_ev), .o_commutation(o_commutation), .o_ratio_irq(o_ratio_irq),
      .o_zero_debug_pin(zdbg), .o_demag_debug_pin(ddbg), .o_stepcfg(o_stepcfg),
      .o_phase(o_phase));
   act_event_source u_act_event_source (.i_clock(i_clock), .o_zero_cross_event(zc_ev),
      .o_demag_event(dm_ev), .o_capture_event(cp_ev), .o_update_event(up_ev));
   // -------------------------------------------------------------
   // Tasks and monitors
   // -------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   // The request stands until the edge at which waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      i_address   <= {idx, 2'b00};
      i_write     <= wr;
      i_read      <= ~wr;
      i_writedata <= {24'h000000, d};
      do begin
         @(posedge i_clock);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 20);
      if (o_waitrequest !== 1'b0) n_mismatch++;
      i_write <= 1'b0;
      i_read  <= 1'b0;
      @(posedge i_clock);
   endtask : bus
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr
   task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, idx, 8'h00);
   endtask : rd
   always @(negedge i_clock) begin
      if (o_commutation === 1'b1) n_comm++;
   end
   // Read data are taken at the very edge at which waitrequest is seen low.
   always @(posedge i_clock) begin
      if (i_read === 1'b1 && o_waitrequest === 1'b0) chk(o_readdata[7:0], exp_q.pop_front());
   end
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   initial begin
      repeat (60000) @(posedge i_clock);
      n_mismatch++;
      end_sim();
   end
   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial begin
      {i_rstn, i_read, i_write, dbg0, i_address, i_writedata} = '0;
      i_byteenable = 4'hf;
      n_mismatch = 0;
      total_checks = 0;
      n_comm = 0;
      void'($urandom(31));
      wgt = 8'($urandom) | 8'h10;
      cfg = 8'($urandom);
      ph  = 8'($urandom);
      repeat (3) @(posedge i_clock);
      i_rstn <= 1'b1;
      @(posedge i_clock);
      for (int i = 0; i < 12; i++) rd(4'(i), 8'h00);
      wr(4'hc, 8'hff);
      rd(4'hc, 8'h00);
      $display("Test reset and map done");
      wr(4'h6, 8'h0f);
      wr(4'h0, 8'h60);
      wr(4'h1, 8'h30);
      wr(4'h5, wgt);
      wr(4'h9, cfg);
      wr(4'ha, ph);
      rd(4'h6, 8'h0f);
      wr(4'h7, 8'hd1);
      wr(4'h0, 8'h11);
      rd(4'h0, 8'h60);
      u_act_event_source.pulse(4'b0001);
      rd(4'h1, 8'h60);
      rd(4'h2, 8'h30);
      rd(4'h0, 8'h00);
      rd(4'h3, 8'((16'(wgt) * 16'h0060) >> 8));
      chk({4'h0, o_stepcfg}, 8'h00);
      $display("Test hardware zero-cross done");
      wr(4'h7, 8'h71);
      wr(4'h0, 8'h70);
      wr(4'h7, 8'hf1);
      repeat (4) @(posedge i_clock);
      chk(8'(n_comm), 8'h00);
      wr(4'h3, 8'h10);
      repeat (2) @(posedge i_clock);
      chk(8'(n_comm), 8'h01);
      rd(4'h3, 8'h70);
      rd(4'h0, 8'h70);
      chk({4'h0, o_stepcfg}, {4'h0, cfg[3:0]});
      chk(o_phase, ph);
      wr(4'h3, 8'h20);
      repeat (2) @(posedge i_clock);
      chk(8'(n_comm), 8'h02);
      u_act_event_source.pulse(4'b0010);
      wr(4'h1, 8'h22);
      rd(4'h2, 8'h22);
      rd(4'h0, 8'h00);
      $display("Test simulated commutation done");
      wr(4'h7, 8'h51);
      wr(4'h6, 8'h05);
      wr(4'h0, 8'h20);
      wr(4'h4, 8'h11);
      wr(4'h8, 8'h07);
      wr(4'h7, 8'hd1);
      u_act_event_source.pulse(4'b0001);
      rd(4'h6, 8'h04);
      rd(4'h8, 8'h02);
      rd(4'h4, 8'h22);
      chk({7'h00, o_ratio_irq}, 8'h01);
      wr(4'h7, 8'h51);
      wr(4'h6, 8'h00);
      wr(4'h0, 8'h20);
      wr(4'h8, 8'h07);
      wr(4'h7, 8'hd1);
      u_act_event_source.pulse(4'b0001);
      rd(4'h6, 8'h00);
      rd(4'h8, 8'h00);
      $display("Test ratio decrement done");
      wr(4'h7, 8'h51);
      wr(4'h0, 8'hf0);
      wr(4'h8, 8'h07);
      wr(4'h7, 8'hd1);
      repeat (40) @(posedge i_clock);
      rd(4'h6, 8'h01);
      rd(4'h8, 8'h05);
      chk({7'h00, o_ratio_irq}, 8'h01);
      wr(4'h7, 8'hd0);
      chk({7'h00, o_ratio_irq}, 8'h00);
      $display("Test ratio increment done");
      wr(4'h7, 8'h51);
      wr(4'h6, 8'h0f);
      wr(4'h0, 8'hff);
      wr(4'h8, 8'h07);
      wr(4'h7, 8'hd1);
      repeat (33000) @(posedge i_clock);
      rd(4'h6, 8'h0f);
      rd(4'h8, 8'h04);
      wr(4'h8, 8'h04);
      rd(4'h8, 8'h00);
      $display("Test top prescaler wrap done");
      wr(4'h5, 8'h00);
      wr(4'h7, 8'hc8);
      u_act_event_source.pulse(4'b0001);
      @(posedge i_clock);
      chk({7'h00, zdbg}, 8'h01);
      @(posedge i_clock);
      chk({7'h00, zdbg}, 8'h01);
      wr(4'h7, 8'h8a);
      repeat (2) @(posedge i_clock);
      dbg0 = ddbg;
      u_act_event_source.pulse(4'b0100);
      repeat (2) @(posedge i_clock);
      chk({7'h00, ddbg}, {7'h00, ~dbg0});
      dbg0 = zdbg;
      u_act_event_source.pulse(4'b1000);
      repeat (2) @(posedge i_clock);
      chk({7'h00, zdbg}, {7'h00, ~dbg0});
      $display("Test debug pins done");
      end_sim();
   end
endmodule : autoswitched_commutation_timer_bench
